// *** ocp_compare_timer.sv ***
/*
 * output compare, forced output and one pulse logic of a 16-bit timer,
 * with its counter, prescaler, captures and an AHB-Lite register slave.
 * assumes pin inputs synchronous to clock and a single bus master.
 */
`timescale 1ns/1ps

// Function
// - counter equal to compare value sets that compare flag
// - enabled match drives stored level on pin; pin low in reset
// - compare flag interrupts only with its enable and mask clear
// - compare flag clears after status read then low byte access
// - high byte write inhibits compare until low byte written
// - disabled pin keeps level; flag and interrupt still work
// - flag and pin update in the count equal to compare
// - flash variant hides compare two and holds its flag zero
// - force bit copies level to pin without flag or interrupt
// - force bits do nothing in one pulse or PWM mode
// - control two bit selects one pulse using capture one, compare one
// - trigger loads FFFC, drives level two, sets flag, loads FFFD
// - trigger capture flag requests interrupt with capture enable
// - capture flag clears after status read then low byte access
// - one pulse match drives level one; equal levels stay constant
// - one pulse never sets compare flag one; flag two still works
// - PWM and one pulse both set means PWM only
// - one pulse: no capture one; capture two still works
// - one pulse: compare two flags time but drives no pin
// - timer clock is CPU clock over 2, 4 or 8, or an external clock edge
// - compare every timer clock; values never altered by hardware
// - counter resets to FFFC in every mode
// - compare registers reset to 8000
module ocp_compare_timer #(
    parameter bit FLASH_TIMER_A = 1'b0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic captureInputOne,
    input wire logic captureInputTwo,
    input wire logic extClock,
    input wire logic cpuIntMask,
    output logic compareOutputPin1,
    output logic compareOutputPin2,
    output logic comparePinEnable1,
    output logic comparePinEnable2,
    output logic timerIrq
);
    import ocp_pkg::*;

    // ==========================================================
    // state
    ocp_ctl1_t ctl1_r;
    ocp_ctl2_t ctl2_r;
    logic [15:0] cnt_r, cmp1_r, cmp2_r, cap1_r, cap2_r;
    logic [3:0] flag_r, arm_r;
    logic inhibit1_r, inhibit2_r, pin1_r, pin2_r, irq_r;
    logic [2:0] div_r;
    logic extPrev_r, cap1Prev_r, cap2Prev_r;
    logic aWr_r, aRd_r;
    logic [7:0] aAddr_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;

    // ==========================================================
    // event terms
    logic addrOk, wrEn, rdDo, extSel, extEdge, tick;
    logic [7:0] rdVal;
    logic [2:0] divTerm;
    logic [15:0] cntNext;
    logic pwmMode, opmMode, cap1Edge, cap2Edge, opmTrig, match1, match2, statusRd;
    logic [3:0] setV, lowAcc, clrV, enV;
    logic force1Wr, force2Wr;

    function automatic logic [2:0] presTerm(input logic [1:0] sel);
        logic [2:0] t;
        t = TERM_DIV4;
        if (sel == CLK_DIV2) begin
            t = TERM_DIV2;
        end else if (sel == CLK_DIV8) begin
            t = TERM_DIV8;
        end
        return t;
    endfunction

    function automatic logic edgeSeen(input logic now, input logic prev,
                                      input logic rising);
        return rising ? (now & ~prev) : (~now & prev);
    endfunction

    function automatic logic hits(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // ==========================================================
    // timer clock enable
    assign divTerm = presTerm(ctl2_r.timerClockSelect);
    assign extSel = ctl2_r.timerClockSelect == CLK_EXT;
    assign extEdge = edgeSeen(extClock, extPrev_r, ctl2_r.extClockEdge);
    assign tick = extSel ? extEdge : (div_r == divTerm);
    assign cntNext = cnt_r + 16'h0001;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            div_r <= 3'h0;
        end else if (extSel || div_r == divTerm) begin
            div_r <= 3'h0;
        end else begin
            div_r <= div_r + 3'h1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            extPrev_r <= 1'b0;
            cap1Prev_r <= 1'b0;
            cap2Prev_r <= 1'b0;
        end else begin
            extPrev_r <= extClock;
            cap1Prev_r <= captureInputOne;
            cap2Prev_r <= captureInputTwo;
        end
    end

    // ==========================================================
    // modes and events
    assign pwmMode = ctl2_r.pwmSelect;
    assign opmMode = ctl2_r.singlePulseSelect & ~ctl2_r.pwmSelect;
    assign cap1Edge = edgeSeen(captureInputOne, cap1Prev_r, ctl1_r.captureEdgeOne);
    assign cap2Edge = edgeSeen(captureInputTwo, cap2Prev_r, ctl2_r.captureEdgeTwo);
    assign opmTrig = opmMode & cap1Edge;
    assign match1 = tick && cntNext == cmp1_r && !inhibit1_r;
    assign match2 = tick && cntNext == cmp2_r && !inhibit2_r;

    // ==========================================================
    // counter
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_r <= CNT_RESET;
        end else if (opmTrig) begin
            cnt_r <= CNT_RESET;
        end else if (tick) begin
            cnt_r <= cntNext;
        end
    end

    // ==========================================================
    // bus slave: writes zero wait, reads one wait state
    assign addrOk = hsel && hready && htrans[1];
    assign wrEn = aWr_r;
    assign rdDo = aRd_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aWr_r <= 1'b0;
            aRd_r <= 1'b0;
            aAddr_r <= 8'h00;
            hrdata_r <= 32'h0;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else if (aRd_r) begin
            aRd_r <= 1'b0;
            aWr_r <= 1'b0;
            hrdata_r <= {24'h0, rdVal};
            hreadyout_r <= 1'b1;
        end else begin
            aWr_r <= addrOk && hwrite;
            aRd_r <= addrOk && !hwrite;
            if (addrOk) begin
                aAddr_r <= haddr[7:0];
                hreadyout_r <= hwrite;
            end
        end
    end

    always_comb begin
        rdVal = 8'h00;
        if (hits(aAddr_r, OFS_CTL_ONE)) begin
            rdVal = ctl1_r;
        end else if (hits(aAddr_r, OFS_CTL_TWO)) begin
            rdVal = ctl2_r;
        end else if (hits(aAddr_r, OFS_STATUS)) begin
            rdVal = {4'h0, flag_r};
        end else if (hits(aAddr_r, OFS_CMP1_HI)) begin
            rdVal = cmp1_r[15:8];
        end else if (hits(aAddr_r, OFS_CMP1_LO)) begin
            rdVal = cmp1_r[7:0];
        end else if (hits(aAddr_r, OFS_CMP2_HI)) begin
            rdVal = FLASH_TIMER_A ? 8'h00 : cmp2_r[15:8];
        end else if (hits(aAddr_r, OFS_CMP2_LO)) begin
            rdVal = FLASH_TIMER_A ? 8'h00 : cmp2_r[7:0];
        end else if (hits(aAddr_r, OFS_CAP1_HI)) begin
            rdVal = cap1_r[15:8];
        end else if (hits(aAddr_r, OFS_CAP1_LO)) begin
            rdVal = cap1_r[7:0];
        end else if (hits(aAddr_r, OFS_CAP2_HI)) begin
            rdVal = cap2_r[15:8];
        end else if (hits(aAddr_r, OFS_CAP2_LO)) begin
            rdVal = cap2_r[7:0];
        end else if (hits(aAddr_r, OFS_CNT_HI)) begin
            rdVal = cnt_r[15:8];
        end else if (hits(aAddr_r, OFS_CNT_LO)) begin
            rdVal = cnt_r[7:0];
        end
    end

    // ==========================================================
    // control and compare registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctl1_r <= CTL1_RESET;
            ctl2_r <= CTL2_RESET;
        end else if (wrEn && hits(aAddr_r, OFS_CTL_ONE)) begin
            ctl1_r <= hwdata[7:0];
        end else if (wrEn && hits(aAddr_r, OFS_CTL_TWO)) begin
            ctl2_r <= hwdata[7:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cmp1_r <= CMP_RESET;
            cmp2_r <= CMP_RESET;
            inhibit1_r <= 1'b0;
            inhibit2_r <= 1'b0;
        end else if (wrEn) begin
            if (hits(aAddr_r, OFS_CMP1_HI)) begin
                cmp1_r[15:8] <= hwdata[7:0];
                inhibit1_r <= 1'b1;
            end else if (hits(aAddr_r, OFS_CMP1_LO)) begin
                cmp1_r[7:0] <= hwdata[7:0];
                inhibit1_r <= 1'b0;
            end else if (hits(aAddr_r, OFS_CMP2_HI)) begin
                cmp2_r[15:8] <= hwdata[7:0];
                inhibit2_r <= 1'b1;
            end else if (hits(aAddr_r, OFS_CMP2_LO)) begin
                cmp2_r[7:0] <= hwdata[7:0];
                inhibit2_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // captures
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cap1_r <= 16'h0000;
            cap2_r <= 16'h0000;
        end else begin
            if (opmTrig) begin
                cap1_r <= CAP_PULSE;
            end else if (cap1Edge && !opmMode && !pwmMode) begin
                cap1_r <= cnt_r;
            end
            if (cap2Edge && !FLASH_TIMER_A) begin
                cap2_r <= cnt_r;
            end
        end
    end

    // ==========================================================
    // flags with two-step clear; set wins over clear
    assign statusRd = rdDo && hits(aAddr_r, OFS_STATUS);
    assign setV[FLG_CMP1] = match1 && !opmMode && !pwmMode;
    assign setV[FLG_CMP2] = match2 && !pwmMode && !FLASH_TIMER_A;
    assign setV[FLG_CAP1] = cap1Edge && !pwmMode;
    assign setV[FLG_CAP2] = cap2Edge && !FLASH_TIMER_A;
    assign lowAcc[FLG_CMP1] = (wrEn || rdDo) && hits(aAddr_r, OFS_CMP1_LO);
    assign lowAcc[FLG_CMP2] = (wrEn || rdDo) && hits(aAddr_r, OFS_CMP2_LO);
    assign lowAcc[FLG_CAP1] = (wrEn || rdDo) && hits(aAddr_r, OFS_CAP1_LO);
    assign lowAcc[FLG_CAP2] = (wrEn || rdDo) && hits(aAddr_r, OFS_CAP2_LO);
    assign clrV = arm_r & lowAcc;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flag_r <= 4'h0;
        end else begin
            flag_r <= setV | (flag_r & ~clrV);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            arm_r <= 4'h0;
        end else begin
            arm_r <= (arm_r | (statusRd ? flag_r : 4'h0)) & ~clrV;
        end
    end

    // ==========================================================
    // compare pins
    assign force1Wr = wrEn && hits(aAddr_r, OFS_CTL_ONE) && hwdata[3]
        && !opmMode && !pwmMode;
    assign force2Wr = wrEn && hits(aAddr_r, OFS_CTL_ONE) && hwdata[4]
        && !opmMode && !pwmMode;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin1_r <= 1'b0;
        end else if (ctl2_r.comparePinEnable1) begin
            if (opmTrig) begin
                pin1_r <= ctl1_r.compareOutputLevel2;
            end else if (match1 && !pwmMode) begin
                pin1_r <= ctl1_r.compareOutputLevel1;
            end else if (force1Wr) begin
                pin1_r <= hwdata[0];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin2_r <= 1'b0;
        end else if (ctl2_r.comparePinEnable2) begin
            if (match2 && !opmMode && !pwmMode) begin
                pin2_r <= ctl1_r.compareOutputLevel2;
            end else if (force2Wr) begin
                pin2_r <= hwdata[1];
            end
        end
    end

    // ==========================================================
    // shared interrupt
    assign enV = {ctl1_r.captureIrqEnable, ctl1_r.captureIrqEnable,
                  ctl1_r.compareIrqEnable, ctl1_r.compareIrqEnable};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= (|(flag_r & enV)) && !cpuIntMask;
        end
    end

    assign hreadyout = hreadyout_r;
    assign hrdata = hrdata_r;
    assign hresp = hresp_r;
    assign compareOutputPin1 = pin1_r;
    assign compareOutputPin2 = pin2_r;
    assign comparePinEnable1 = ctl2_r.comparePinEnable1;
    assign comparePinEnable2 = ctl2_r.comparePinEnable2;
    assign timerIrq = irq_r;

    // ==========================================================
    // checks
    a_flag_one_set: assert property (@(posedge clock) disable iff (rst)
        match1 && !opmMode && !pwmMode |=> flag_r[FLG_CMP1])
        else $error("compare flag one not set on match");

    a_pin_level: assert property (@(posedge clock) disable iff (rst)
        match1 && !opmTrig && !pwmMode && ctl2_r.comparePinEnable1
        |=> pin1_r == $past(ctl1_r.compareOutputLevel1))
        else $error("compare pin one missed its level");

    a_irq_gate: assert property (@(posedge clock) disable iff (rst)
        irq_r |-> |($past(flag_r) & $past(enV)) && !$past(cpuIntMask))
        else $error("interrupt raised without enabled flag");

    a_clear_steps: assert property (@(posedge clock) disable iff (rst)
        $fell(flag_r[FLG_CMP1]) |-> $past(arm_r[FLG_CMP1]) && $past(lowAcc[FLG_CMP1]))
        else $error("compare flag cleared without two steps");

    a_inhibit_hold: assert property (@(posedge clock) disable iff (rst)
        inhibit1_r && !opmTrig |=> $stable(pin1_r) || $past(force1Wr))
        else $error("inhibited compare moved the pin");

    a_flash_zero: assert property (@(posedge clock) disable iff (rst)
        FLASH_TIMER_A |-> !flag_r[FLG_CMP2])
        else $error("compare flag two set in flash variant");

    a_force_noflag: assert property (@(posedge clock) disable iff (rst)
        force1Wr && !match1 && !opmTrig && ctl2_r.comparePinEnable1
        |=> pin1_r == $past(hwdata[0]) && !$rose(flag_r[FLG_CMP1]))
        else $error("forced output wrong or flagged");

    a_opm_trigger: assert property (@(posedge clock) disable iff (rst)
        opmTrig |=> cnt_r == CNT_RESET && cap1_r == CAP_PULSE && flag_r[FLG_CAP1])
        else $error("one pulse trigger did not load counter and capture");

    a_opm_noflag: assert property (@(posedge clock) disable iff (rst)
        opmMode && !flag_r[FLG_CMP1] |=> !flag_r[FLG_CMP1])
        else $error("compare flag one set in one pulse mode");
endmodule

// *** ocp_pkg.sv ***
/*
 * constants, register offsets and control layouts of the compare block.
 * assumes one 200 MHz clock and a single AHB-Lite master.
 */
package ocp_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTL_ONE = 8'h00;
    localparam logic [7:0] OFS_CTL_TWO = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_CMP1_HI = 8'h0c;
    localparam logic [7:0] OFS_CMP1_LO = 8'h10;
    localparam logic [7:0] OFS_CMP2_HI = 8'h14;
    localparam logic [7:0] OFS_CMP2_LO = 8'h18;
    localparam logic [7:0] OFS_CAP1_HI = 8'h1c;
    localparam logic [7:0] OFS_CAP1_LO = 8'h20;
    localparam logic [7:0] OFS_CAP2_HI = 8'h24;
    localparam logic [7:0] OFS_CAP2_LO = 8'h28;
    localparam logic [7:0] OFS_CNT_HI = 8'h2c;
    localparam logic [7:0] OFS_CNT_LO = 8'h30;

    // ==========================================================
    // status bit positions
    localparam int FLG_CMP1 = 0;
    localparam int FLG_CMP2 = 1;
    localparam int FLG_CAP1 = 2;
    localparam int FLG_CAP2 = 3;

    // ==========================================================
    // reset and load values
    localparam logic [15:0] CNT_RESET = 16'hfffc;
    localparam logic [15:0] CAP_PULSE = 16'hfffd;
    localparam logic [15:0] CMP_RESET = 16'h8000;

    // ==========================================================
    // prescaler selection and terminal counts
    localparam logic [1:0] CLK_DIV4 = 2'h0;
    localparam logic [1:0] CLK_DIV2 = 2'h1;
    localparam logic [1:0] CLK_DIV8 = 2'h2;
    localparam logic [1:0] CLK_EXT = 2'h3;
    localparam logic [2:0] TERM_DIV2 = 3'h1;
    localparam logic [2:0] TERM_DIV4 = 3'h3;
    localparam logic [2:0] TERM_DIV8 = 3'h7;

    // ==========================================================
    // control register layouts
    typedef struct packed {
        logic captureIrqEnable;
        logic compareIrqEnable;
        logic spare;
        logic forceOutputLevel2;
        logic forceOutputLevel1;
        logic captureEdgeOne;
        logic compareOutputLevel2;
        logic compareOutputLevel1;
    } ocp_ctl1_t;

    typedef struct packed {
        logic comparePinEnable1;
        logic comparePinEnable2;
        logic singlePulseSelect;
        logic pwmSelect;
        logic [1:0] timerClockSelect;
        logic captureEdgeTwo;
        logic extClockEdge;
    } ocp_ctl2_t;

    localparam ocp_ctl1_t CTL1_RESET = 8'h00;
    localparam ocp_ctl2_t CTL2_RESET = 8'h00;
endpackage

// *** ocp_pin_partner.sv ***
/*
 * pin-side partner: capture edge source, free external clock, pin load.
 * assumes fire requests change just after a rising clock edge.
 */
`timescale 1ns/1ps
module ocp_pin_partner (
    input wire logic clock,
    input wire logic rst,
    input wire logic fireOne,
    input wire logic fireTwo,
    input wire logic loadPin,
    output logic captureInputOne,
    output logic captureInputTwo,
    output logic extClock,
    output logic [15:0] highCycles
);
    logic [2:0] divCnt_r;
    // ==========================================
    // trigger edges and external clock, one rising edge per 16 cycles
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            captureInputOne <= 1'b0;
            captureInputTwo <= 1'b0;
            divCnt_r <= 3'h0;
            extClock <= 1'b0;
        end else begin
            captureInputOne <= fireOne;
            captureInputTwo <= fireTwo;
            divCnt_r <= divCnt_r + 3'h1;
            if (divCnt_r == 3'h7) begin
                extClock <= ~extClock;
            end
        end
    end
    // ==========================================
    // pin load: cycles spent high since the last trigger
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            highCycles <= 16'h0;
        end else if (fireOne && !captureInputOne) begin
            highCycles <= 16'h0;
        end else if (loadPin) begin
            highCycles <= highCycles + 16'h1;
        end
    end
endmodule

// *** tb.sv ***
/*
 * self-checking bench for the compare timer, registers over AHB-Lite.
 * assumes the default variant and this bench as the only bus master.
 */
`timescale 1ns/1ps
module tb;
    import ocp_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic cpuIntMask = 1'b0;
    logic fireOne = 1'b0;
    logic fireTwo = 1'b0;
    logic hreadyout, hresp, captureInputOne, captureInputTwo, extClock, timerIrq;
    logic compareOutputPin1, compareOutputPin2, comparePinEnable1, comparePinEnable2;
    logic [31:0] hrdata;
    logic [15:0] highCycles;
    logic [7:0] rdv, hiv;
    logic [1:0] sel [4] = '{CLK_DIV2, CLK_DIV4, CLK_DIV8, CLK_EXT};
    int div [4] = '{2, 4, 8, 16};
    int err_count = 0;
    int cmp_count = 0;
    int n;

    always #2.5 clock = ~clock;

    ocp_compare_timer u_ocp_compare_timer (.clock(clock), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .captureInputOne(captureInputOne), .captureInputTwo(captureInputTwo),
        .extClock(extClock), .cpuIntMask(cpuIntMask), .compareOutputPin1(compareOutputPin1),
        .compareOutputPin2(compareOutputPin2), .comparePinEnable1(comparePinEnable1),
        .comparePinEnable2(comparePinEnable2), .timerIrq(timerIrq));

    ocp_pin_partner u_ocp_pin_partner (.clock(clock), .rst(rst), .fireOne(fireOne),
        .fireTwo(fireTwo), .loadPin(compareOutputPin1), .captureInputOne(captureInputOne),
        .captureInputTwo(captureInputTwo), .extClock(extClock), .highCycles(highCycles));

    // ==========================================
    // reporting
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic timed_out();
        err_count++;
        $display("Error at %0t: wait bound used up, got %h expected %h", $time, 1'b0, 1'b1);
        final_report();
    endtask

    // ==========================================
    // bus and pin helpers
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] wd,
            output logic [7:0] rd);
        int k;
        k = 0;
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do begin
            @(posedge clock);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do begin
            @(posedge clock);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) timed_out();
        rd = hrdata[7:0];
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] unused;
        xfer(a, 1'b1, d, unused);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        xfer(a, 1'b0, 8'h0, rdv);
        chk(rdv, e);
    endtask

    task automatic wait_pin(input logic v, input int bound);
        int k;
        k = 0;
        while (compareOutputPin1 !== v && k < bound) begin
            @(posedge clock);
            k++;
        end
        if (k >= bound) timed_out();
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (10) @(posedge clock);
        chk({6'h0, compareOutputPin1, timerIrq}, 8'h00);
        rst <= 1'b0;
        rd_chk(OFS_CNT_HI, 8'hff);
        rd_chk(OFS_CMP1_HI, 8'h80);
        rd_chk(OFS_CMP1_LO, 8'h00);
        // plain compare, inhibit, clear
        wr(OFS_CTL_ONE, 8'h43);
        wr(OFS_CTL_TWO, 8'h84);
        xfer(OFS_CNT_HI, 1'b0, 8'h0, hiv);
        wr(OFS_CMP1_HI, hiv + 8'h1);
        n = 0;
        do begin
            xfer(OFS_CNT_HI, 1'b0, 8'h0, rdv);
            n++;
        end while (rdv !== hiv + 8'h2 && n < 1000);
        if (n >= 1000) timed_out();
        rd_chk(OFS_STATUS, 8'h00);
        wr(OFS_CMP1_HI, hiv + 8'h3);
        rd_chk(OFS_STATUS, 8'h00);
        wr(OFS_CMP1_LO, 8'h00);
        wr(OFS_CMP2_HI, hiv + 8'h3);
        wr(OFS_CMP2_LO, 8'h00);
        wait_pin(1'b1, 1200);
        repeat (2) @(posedge clock);
        chk({4'h0, compareOutputPin2, comparePinEnable2, comparePinEnable1, timerIrq},
            8'h03);
        cpuIntMask <= 1'b1;
        repeat (3) @(posedge clock);
        chk({7'h0, timerIrq}, 8'h00);
        cpuIntMask <= 1'b0;
        rd_chk(OFS_CMP1_LO, 8'h00);
        rd_chk(OFS_STATUS, 8'h03);
        rd_chk(OFS_CMP1_LO, 8'h00);
        rd_chk(OFS_STATUS, 8'h02);
        chk({7'h0, timerIrq}, 8'h01);
        wr(OFS_CMP2_LO, 8'h00);
        rd_chk(OFS_STATUS, 8'h00);
        chk({7'h0, timerIrq}, 8'h00);
        rd_chk(OFS_CMP1_HI, hiv + 8'h3);
        wr(OFS_CTL_ONE, 8'h48);
        repeat (2) @(posedge clock);
        chk({6'h0, compareOutputPin1, timerIrq}, 8'h00);
        rd_chk(OFS_STATUS, 8'h00);
        // single pulse at every timer clock choice
        wr(OFS_CMP1_HI, 8'h00);
        wr(OFS_CMP1_LO, 8'h10);
        wr(OFS_CTL_ONE, 8'h86);
        for (int i = 0; i < 4; i++) begin
            xfer(OFS_STATUS, 1'b0, 8'h0, rdv);
            xfer(OFS_CAP1_LO, 1'b0, 8'h0, rdv);
            xfer(OFS_CAP2_LO, 1'b0, 8'h0, rdv);
            repeat (2) @(posedge clock);
            chk({7'h0, timerIrq}, 8'h00);
            wr(OFS_CTL_TWO, {4'ha, sel[i], 1'b1, sel[i] == CLK_EXT});
            fireOne <= 1'b1;
            fireTwo <= 1'b1;
            repeat (3) @(posedge clock);
            fireOne <= 1'b0;
            fireTwo <= 1'b0;
            wait_pin(1'b1, 20);
            repeat (2) @(posedge clock);
            chk({7'h0, timerIrq}, 8'h01);
            wait_pin(1'b0, 600);
            repeat (2) @(posedge clock);
            chk({7'h0, highCycles >= 19 * div[i] && highCycles <= 21 * div[i]}, 8'h01);
        end
        wr(OFS_CTL_ONE, 8'h8f);
        repeat (2) @(posedge clock);
        chk({7'h0, compareOutputPin1}, 8'h00);
        xfer(OFS_STATUS, 1'b0, 8'h0, rdv);
        chk(rdv & 8'h0d, 8'h0c);
        rd_chk(OFS_CAP1_HI, 8'hff);
        rd_chk(OFS_CAP1_LO, 8'hfd);
        xfer(OFS_STATUS, 1'b0, 8'h0, rdv);
        chk(rdv & 8'h0d, 8'h08);
        // both mode bits set: trigger must be ignored
        wr(OFS_CTL_TWO, 8'hbf);
        fireOne <= 1'b1;
        repeat (3) @(posedge clock);
        fireOne <= 1'b0;
        repeat (3) @(posedge clock);
        xfer(OFS_STATUS, 1'b0, 8'h0, rdv);
        chk((rdv & 8'h05) | {7'h0, compareOutputPin1}, 8'h00);
        final_report();
    end
endmodule
